// [src/icl_regs.sv]
// What this block does
// - Low voltage byte weights 128 and 64 mV
// - Reserved voltage bits, current low byte ignored
// - Ten milliohm range 50 to 6350 mA
// - Current limit clamped at upper boundary
// - Ten milliohm code zero gives 50 mA
// - Ten milliohm default 3.25 A, restored on removal
// - Five milliohm code zero gives 100 mA
// - Five milliohm default 3.2 A, restored on removal
// - Maximum is nominal plus 100/200 mA
// - Sense select: 0 ten, 1 five milliohm
// - Five milliohm weights 6400 down to 100 mA
// - Reset sets current bit 5 and option bits 0 and 1
// - Five milliohm value is maximum current
// - External pin feedback replaces internal loop
// - External pin off by enable or above 4 V
// - Sense select defaults to five milliohm
// - Read-only maker code at 2Eh
// - Read-only part code at 2Fh
// - Voltage limit is 3.2 V plus weights
// - High voltage byte weights 8192 to 256 mV
// - Below voltage limit, regulation is entered
`include "icl_defs.svh"

module icl_regs
   import icl_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR   = 7'h09, // Arbitrary bus address
   parameter logic [7:0] MAKER_CODE = 8'h5A, // Arbitrary value
   parameter logic [7:0] PART_CODE  = 8'hA5  // Arbitrary value
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        scl,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe,
   input  wire logic        adapter_present,
   input  wire logic [15:0] vin_mv,
   input  wire logic [15:0] ext_pin_mv,
   output logic [15:0]      vin_limit_mv,
   output logic             vin_regulation_active,
   output logic             ext_limit_active,
   output logic [13:0]      iin_limit_ma,
   output logic [13:0]      iin_max_ma,
   output logic             iin_limit_is_max
);

   icl_state_t  s;
   icl_state_t  n;
   logic        rise;
   logic        fall;
   logic        start_c;
   logic        stop_c;
   logic        wr_en;
   logic        load_rd;
   logic [7:0]  rd_addr;
   logic [7:0]  rd_byte;

   icl_lim_if lim ();

   ////////////////////////////////////////////////////////////////////////////
   // Register read mux
   function automatic logic [7:0] read_reg(input logic [7:0] a, input icl_state_t q);
      case (a)
         `ICL_VIN_LO_OFS: read_reg = {q.vin_lo, 6'h00};
         `ICL_VIN_HI_OFS: read_reg = {2'h0, q.vin_hi};
         `ICL_IIN_LO_OFS: read_reg = 8'h00;
         `ICL_IIN_HI_OFS: read_reg = {1'b0, q.iin_code};
         `ICL_MAKER_OFS:  read_reg = MAKER_CODE;
         `ICL_PART_OFS:   read_reg = PART_CODE;
         `ICL_OPT_OFS:    read_reg = {6'h00, q.ext_en, q.sense};
         default:         read_reg = 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Limit decoder
   assign lim.code  = s.iin_code;
   assign lim.sense = s.sense;

   icl_limit_decode u_dec (
      .lim (lim)
   );

   // Bus line events
   assign rise    = scl & ~s.scl_q;
   assign fall    = ~scl & s.scl_q;
   assign start_c = scl & s.scl_q & s.sda_q & ~sda_in;
   assign stop_c  = scl & s.scl_q & ~s.sda_q & sda_in;

   ////////////////////////////////////////////////////////////////////////////
   // Next state
   always_comb begin
      n       = s;
      wr_en   = 1'b0;
      load_rd = 1'b0;
      rd_addr = 8'h00;
      rd_byte = 8'h00;
      n.scl_q = scl;
      n.sda_q = sda_in;
      n.sda_o = 1'b0;

      // Serial slave sequencing
      case (s.st)
         ST_IDLE: begin
            n.sda_oe = 1'b0;
         end
         ST_ADDR, ST_REG, ST_WDATA: begin
            if (rise) begin
               n.shreg   = {s.shreg[6:0], sda_in};
               n.bit_cnt = s.bit_cnt + 4'h1;
            end else if (fall && s.bit_cnt == 4'h8) begin
               n.bit_cnt = 4'h0;
               if (s.st == ST_ADDR) begin
                  if (s.shreg[7:1] == DEV_ADDR) begin
                     n.rw     = s.shreg[0];
                     n.sda_oe = 1'b1;
                     n.st     = ST_ADDR_ACK;
                  end else begin
                     n.st = ST_IDLE;
                  end
               end else if (s.st == ST_REG) begin
                  n.ptr     = s.shreg;
                  n.snap_ok = 1'b0;
                  n.hold_ok = 1'b0;
                  n.sda_oe  = 1'b1;
                  n.st      = ST_REG_ACK;
               end else begin
                  wr_en    = 1'b1;
                  n.sda_oe = 1'b1;
                  n.st     = ST_WDATA_ACK;
               end
            end
         end
         ST_ADDR_ACK: begin
            if (fall) begin
               n.sda_oe = 1'b0;
               if (s.rw) begin
                  load_rd = 1'b1;
               end else begin
                  n.st = ST_REG;
               end
            end
         end
         ST_REG_ACK, ST_WDATA_ACK: begin
            if (fall) begin
               n.sda_oe = 1'b0;
               n.st     = ST_WDATA;
            end
         end
         ST_RDATA: begin
            if (fall) begin
               if (s.bit_cnt == 4'h7) begin
                  n.sda_oe = 1'b0;
                  n.st     = ST_RACK;
               end else begin
                  n.bit_cnt = s.bit_cnt + 4'h1;
                  n.shreg   = {s.shreg[6:0], 1'b0};
                  n.sda_oe  = ~s.shreg[6];
               end
            end
         end
         ST_RACK: begin
            if (rise) begin
               n.nack = sda_in;
            end else if (fall) begin
               if (s.nack) begin
                  n.st = ST_IDLE;
               end else begin
                  n.ptr   = s.ptr + 8'h01;
                  load_rd = 1'b1;
               end
            end
         end
         default: begin
            n.st     = ST_IDLE;
            n.sda_oe = 1'b0;
         end
      endcase

      // Read byte load, high byte taken from snapshot of its pair
      if (load_rd) begin
         rd_addr = n.ptr;
         rd_byte = read_reg(rd_addr, s);
         if (!rd_addr[0]) begin
            n.hi_snap = read_reg(rd_addr | 8'h01, s);
            n.snap_ok = 1'b1;
         end else if (s.snap_ok) begin
            rd_byte   = s.hi_snap;
            n.snap_ok = 1'b0;
         end
         n.st      = ST_RDATA;
         n.bit_cnt = 4'h0;
         n.shreg   = rd_byte;
         n.sda_oe  = ~rd_byte[7];
      end

      // Start and stop conditions
      if (start_c) begin
         n.st      = ST_ADDR;
         n.bit_cnt = 4'h0;
         n.sda_oe  = 1'b0;
      end else if (stop_c) begin
         n.st     = ST_IDLE;
         n.sda_oe = 1'b0;
      end

      // Register writes, word committed at the high byte
      if (wr_en) begin
         n.ptr = s.ptr + 8'h01;
         case (s.ptr)
            `ICL_VIN_LO_OFS: begin
               n.hold    = s.shreg;
               n.hold_ok = 1'b1;
            end
            `ICL_VIN_HI_OFS: begin
               n.hold_ok = 1'b0;
               if (s.shreg[7:6] == 2'h0) begin
                  n.vin_hi = s.shreg[`ICL_VIN_HI_MSB:0];
                  if (s.hold_ok) begin
                     n.vin_lo = s.hold[`ICL_VIN_LO_MSB:`ICL_VIN_LO_LSB];
                  end
               end
            end
            `ICL_IIN_HI_OFS: begin
               if (!s.shreg[`ICL_IIN_RSV_BIT]) begin
                  n.iin_code = s.shreg[6:0];
               end
            end
            `ICL_OPT_OFS: begin
               n.sense  = s.shreg[`ICL_OPT_SENSE_BIT];
               n.ext_en = s.shreg[`ICL_OPT_EXT_BIT];
            end
            default: begin
               n.hold_ok = s.hold_ok;
            end
         endcase
      end

      // Adapter removal restores the default code
      n.adapter_q = adapter_present;
      if (s.adapter_q && !adapter_present) begin
         n.iin_code = n.sense ? `ICL_IIN_DEF_5M : `ICL_IIN_DEF_10M;
      end

      // Registered outputs
      n.vin_limit = `ICL_VIN_OFS_MV + {2'h0, s.vin_hi, s.vin_lo, 6'h00};
      n.vin_reg   = vin_mv < s.vin_limit;
      n.ext_act   = s.ext_en && (ext_pin_mv <= `ICL_EXT_OFF_MV);
      n.iin_lim   = lim.nominal;
      n.iin_max   = lim.maxim;
      n.is_max    = s.sense;
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge clk) begin
      if (srst) begin
         s           <= '0;
         s.scl_q     <= 1'b1;
         s.sda_q     <= 1'b1;
         s.st        <= ST_IDLE;
         s.iin_code  <= `ICL_IIN_DEF_5M;
         s.sense     <= `ICL_SENSE_RST;
         s.ext_en    <= `ICL_EXT_RST;
         s.vin_limit <= `ICL_VIN_OFS_MV;
      end else begin
         s <= n;
      end
   end

   assign sda_out               = s.sda_o;
   assign sda_oe                = s.sda_oe;
   assign vin_limit_mv          = s.vin_limit;
   assign vin_regulation_active = s.vin_reg;
   assign ext_limit_active      = s.ext_act;
   assign iin_limit_ma          = s.iin_lim;
   assign iin_max_ma            = s.iin_max;
   assign iin_limit_is_max      = s.is_max;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_removal;
      s.adapter_q && !adapter_present;
   endsequence

   sequence s_bad_cur_write;
      wr_en && s.ptr == `ICL_IIN_HI_OFS && s.shreg[7];
   endsequence

   a_vin_weights: assert property (
      !$past(srst) |-> vin_limit_mv ==
         `ICL_VIN_OFS_MV + {2'h0, $past(s.vin_hi), $past(s.vin_lo), 6'h00})
      else $error("Voltage limit weights wrong");

   a_cur_low_zero: assert property (
      (load_rd && rd_addr == `ICL_IIN_LO_OFS) |=> s.shreg == 8'h00)
      else $error("Current low byte not zero");

   a_cur_clamp: assert property (
      iin_limit_ma <= (iin_limit_is_max ? `ICL_CLAMP_5M_MA : `ICL_CLAMP_10M_MA))
      else $error("Current limit above clamp");

   a_zero_ten: assert property (
      (s.iin_code == 7'h00 && !s.sense)
         |=> iin_limit_ma == `ICL_ZERO_10M_MA)
      else $error("Code zero offset wrong at ten milliohm");

   a_zero_five: assert property (
      (s.iin_code == 7'h00 && s.sense && $stable(s.iin_code) && $stable(s.sense))
         |=> iin_limit_ma == `ICL_ZERO_5M_MA)
      else $error("Code zero offset wrong at five milliohm");

   a_removal_dflt: assert property (
      (s_removal ##1 (!wr_en && $stable(s.sense)))
         |=> iin_limit_ma == (s.sense ? `ICL_DEF_5M_MA : `ICL_DEF_10M_MA))
      else $error("Default not restored on removal");

   a_max_offset: assert property (
      !$past(srst) |-> iin_max_ma ==
         iin_limit_ma + (iin_limit_is_max ? `ICL_MAX_5M_MA : `ICL_MAX_10M_MA))
      else $error("Maximum offset wrong");

   a_reset_dflt: assert property (
      $past(srst) |-> s.iin_code == `ICL_IIN_DEF_5M && s.sense == `ICL_SENSE_RST)
      else $error("Reset defaults wrong");

   a_bad_write: assert property (
      (s_bad_cur_write ##0 !(s.adapter_q && !adapter_present)) |=> $stable(s.iin_code))
      else $error("Invalid write changed current code");

   a_ext_off: assert property (
      ext_limit_active |-> $past(s.ext_en) && $past(ext_pin_mv) <= `ICL_EXT_OFF_MV)
      else $error("External pin active while disabled");

   a_vin_reg: assert property (
      !$past(srst) |-> vin_regulation_active == ($past(vin_mv) < $past(s.vin_limit)))
      else $error("Voltage regulation flag wrong");

endmodule

// [common/icl_defs.svh]
`ifndef ICL_DEFS_SVH
`define ICL_DEFS_SVH

// Register offsets
`define ICL_VIN_LO_OFS    8'h0A
`define ICL_VIN_HI_OFS    8'h0B
`define ICL_IIN_LO_OFS    8'h0E
`define ICL_IIN_HI_OFS    8'h0F
`define ICL_MAKER_OFS     8'h2E
`define ICL_PART_OFS      8'h2F
`define ICL_OPT_OFS       8'h30

// Field positions
`define ICL_VIN_LO_MSB    7
`define ICL_VIN_LO_LSB    6
`define ICL_VIN_HI_MSB    5
`define ICL_IIN_RSV_BIT   7
`define ICL_OPT_SENSE_BIT 0
`define ICL_OPT_EXT_BIT   1

// Reset values and removal defaults
`define ICL_IIN_DEF_5M    7'h20
`define ICL_IIN_DEF_10M   7'h41
`define ICL_SENSE_RST     1'b1
`define ICL_EXT_RST       1'b1

// Scaling, in mA or mV
`define ICL_VIN_OFS_MV    16'h0C80
`define ICL_STEP_10M_MA   14'h0032
`define ICL_STEP_5M_MA    14'h0064
`define ICL_ZERO_10M_MA   14'h0032
`define ICL_ZERO_5M_MA    14'h0064
`define ICL_CLAMP_10M_MA  14'h18CE
`define ICL_CLAMP_5M_MA   14'h2710
`define ICL_MAX_10M_MA    14'h0064
`define ICL_MAX_5M_MA     14'h00C8
`define ICL_DEF_10M_MA    14'h0CB2
`define ICL_DEF_5M_MA     14'h0C80
`define ICL_EXT_OFF_MV    16'h0FA0

`endif

// [common/icl_pkg.sv]
`include "icl_defs.svh"

package icl_pkg;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'b0000,
      ST_ADDR      = 4'b0001,
      ST_ADDR_ACK  = 4'b0010,
      ST_REG       = 4'b0011,
      ST_REG_ACK   = 4'b0100,
      ST_WDATA     = 4'b0101,
      ST_WDATA_ACK = 4'b0110,
      ST_RDATA     = 4'b0111,
      ST_RACK      = 4'b1000
   } icl_state_e_t;

   typedef struct packed {
      icl_state_e_t st;
      logic         scl_q;
      logic         sda_q;
      logic [3:0]   bit_cnt;
      logic [7:0]   shreg;
      logic         rw;
      logic         nack;
      logic [7:0]   ptr;
      logic [7:0]   hold;
      logic         hold_ok;
      logic [7:0]   hi_snap;
      logic         snap_ok;
      logic [1:0]   vin_lo;
      logic [5:0]   vin_hi;
      logic [6:0]   iin_code;
      logic         sense;
      logic         ext_en;
      logic         adapter_q;
      logic         sda_o;
      logic         sda_oe;
      logic [15:0]  vin_limit;
      logic         vin_reg;
      logic         ext_act;
      logic [13:0]  iin_lim;
      logic [13:0]  iin_max;
      logic         is_max;
   } icl_state_t;

endpackage

// [common/icl_lim_if.sv]
interface icl_lim_if;
   logic [6:0]  code;
   logic        sense;
   logic [13:0] nominal;
   logic [13:0] maxim;

   modport ctrl (output code, output sense, input nominal, input maxim);
   modport dec  (input code, input sense, output nominal, output maxim);
endinterface

// [src/icl_limit_decode.sv]
`include "icl_defs.svh"

module icl_limit_decode (
   icl_lim_if.dec lim
);

   logic [13:0] raw;
   logic [13:0] clamp;

   // Code to milliamps, per sense scaling
   always_comb begin
      if (lim.sense) begin
         raw   = (lim.code == 7'h00) ? `ICL_ZERO_5M_MA : 14'(lim.code) * `ICL_STEP_5M_MA;
         clamp = `ICL_CLAMP_5M_MA;
      end else begin
         raw   = (lim.code == 7'h00) ? `ICL_ZERO_10M_MA : 14'(lim.code) * `ICL_STEP_10M_MA;
         clamp = `ICL_CLAMP_10M_MA;
      end
      // Upper boundary clamp
      lim.nominal = (raw > clamp) ? clamp : raw;
      // Maximum limit above nominal
      lim.maxim = lim.nominal + (lim.sense ? `ICL_MAX_5M_MA : `ICL_MAX_10M_MA);
   end

endmodule

// [dv/icl_host_model.sv]
module icl_host_model (
   input  wire logic clk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_oe
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] DEV = 7'h09;

   // Bus idles released, pulled high
   initial begin
      scl = 1'b1;
      sda_oe = 1'b0;
   end

   // Whole clock cycles
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Data moves while scl low, sampled mid high
   task automatic bit_io(input logic b, output logic r);
      sda_oe <= ~b;
      tick(2);
      scl <= 1'b1;
      tick(2);
      r = sda_line;
      tick(2);
      scl <= 1'b0;
      tick(2);
   endtask

   // Eight bits then the acknowledge slot
   task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx);
      logic b;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], b);
         rx[i] = b;
      end
      bit_io(last, b);
   endtask

   // Start or repeated start
   task automatic start();
      tick(1);
      sda_oe <= 1'b0;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_oe <= 1'b1;
      tick(4);
      scl <= 1'b0;
      tick(2);
   endtask

   // Stop leaves the bus released
   task automatic stop();
      sda_oe <= 1'b1;
      tick(2);
      scl <= 1'b1;
      tick(4);
      sda_oe <= 1'b0;
      tick(4);
   endtask

   // Single byte write; data byte sent as given, top bit not forced to zero
   task automatic wr8(input logic [7:0] p, input logic [7:0] d);
      logic [7:0] x;
      start();
      byte_io({DEV, 1'b0}, 1'b1, x);
      byte_io(p, 1'b1, x);
      byte_io(d, 1'b1, x);
      stop();
   endtask

   // Word write, low address byte first
   task automatic wr16(input logic [7:0] p, input logic [15:0] w);
      logic [7:0] x;
      start();
      byte_io({DEV, 1'b0}, 1'b1, x);
      byte_io(p, 1'b1, x);
      byte_io(w[7:0], 1'b1, x);
      byte_io(w[15:8], 1'b1, x);
      stop();
   endtask

   // Pointer write, repeated start, one byte read then nack
   task automatic rd8(input logic [7:0] p, output logic [7:0] v);
      logic [7:0] x;
      start();
      byte_io({DEV, 1'b0}, 1'b1, x);
      byte_io(p, 1'b1, x);
      start();
      byte_io({DEV, 1'b1}, 1'b1, x);
      byte_io(8'hFF, 1'b1, v);
      stop();
   endtask
endmodule

// [dv/tb.sv]
module tb;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic        k;
      logic [15:0] v;
   } icl_note_t;

   localparam logic [7:0]  MAKER = 8'h5A; // Arbitrary value
   localparam logic [7:0]  PART  = 8'hA5; // Arbitrary value
   localparam logic [15:0] VW [4] = '{16'h3FC0, 16'h0080, 16'h0040, 16'h017F};
   localparam logic [6:0]  CW [5] = '{7'h00, 7'h01, 7'h64, 7'h65, 7'h7F};

   logic        clk;
   logic        srst;
   logic        adapter_present;
   logic        scl;
   logic        h_oe;
   logic        d_oe;
   logic        d_out;
   logic        sda_line;
   logic [15:0] vin_mv;
   logic [15:0] ext_pin_mv;
   logic [15:0] vin_lim;
   logic [13:0] iin_lim;
   logic [13:0] iin_max;
   logic        vreg;
   logic        ext_act;
   logic        is_max;
   logic        res_stb;
   logic        res_k;
   logic [15:0] res_v;
   icl_note_t   exp_q[$];
   int          mismatches;
   int          n_tests;
   int          cyc;

   // Open-drain data line with pull-up, device level shown while enabled
   assign sda_line = ~h_oe & (~d_oe | d_out);

   icl_regs #(
      .DEV_ADDR   (7'h09),
      .MAKER_CODE (MAKER),
      .PART_CODE  (PART)
   ) icl_regs_i (
      .clk                   (clk),
      .srst                  (srst),
      .scl                   (scl),
      .sda_in                (sda_line),
      .sda_out               (d_out),
      .sda_oe                (d_oe),
      .adapter_present       (adapter_present),
      .vin_mv                (vin_mv),
      .ext_pin_mv            (ext_pin_mv),
      .vin_limit_mv          (vin_lim),
      .vin_regulation_active (vreg),
      .ext_limit_active      (ext_act),
      .iin_limit_ma          (iin_lim),
      .iin_max_ma            (iin_max),
      .iin_limit_is_max      (is_max)
   );

   icl_host_model icl_host_model_i (
      .clk      (clk),
      .sda_line (sda_line),
      .scl      (scl),
      .sda_oe   (h_oe)
   );

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Expected values
   function automatic logic [13:0] nom_ma(input logic [6:0] c, input logic s);
      if (c == 7'h00)
         return s ? 14'h0064 : 14'h0032;
      if (s && c > 7'h64)
         return 14'h2710;
      return s ? 14'(c) * 14'h0064 : 14'(c) * 14'h0032;
   endfunction

   function automatic logic [15:0] vlim(input logic [15:0] w);
      return 16'h0C80 + 16'({w[13:8], w[7:6]}) * 16'h0040;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Compare and report
   task automatic cmp_reg(input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t register byte %h expected %h", $time, g, e);
      end
   endtask

   task automatic cmp_out(input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         mismatches++;
         $display("ERROR %0t output value %h expected %h", $time, g, e);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // Note the expectation, then post the observed result
   task automatic note(input logic k, input logic [15:0] e, input logic [15:0] g);
      exp_q.push_back('{k, e});
      res_k <= k;
      res_v <= g;
      res_stb <= 1'b1;
      @(posedge clk);
      res_stb <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd_chk(input logic [7:0] p, input logic [7:0] e);
      logic [7:0] v;
      icl_host_model_i.rd8(p, v);
      note(1'b0, {8'h00, e}, {8'h00, v});
   endtask

   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic out_chk(input logic [15:0] e, input logic [15:0] g);
      note(1'b1, e, g);
   endtask

   task automatic lim_chk(input logic [6:0] c, input logic s);
      settle();
      out_chk({2'b00, nom_ma(c, s)}, {2'b00, iin_lim});
      out_chk({2'b00, nom_ma(c, s) + (s ? 14'h00C8 : 14'h0064)}, {2'b00, iin_max});
      out_chk({15'h0000, s}, {15'h0000, is_max});
   endtask

   // Results checked in arrival order
   always @(posedge clk) begin
      icl_note_t n;
      if (res_stb === 1'b1) begin
         if (exp_q.size() == 0) begin
            mismatches++;
            $display("ERROR %0t result without expectation", $time);
         end else begin
            n = exp_q.pop_front();
            if (n.k)
               cmp_out(n.v, res_v);
            else
               cmp_reg(n.v[7:0], res_v[7:0]);
         end
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         mismatches++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [15:0] v;
      logic [6:0]  c;
      logic        s;
      srst = 1'b1;
      adapter_present = 1'b1;
      vin_mv = 16'h1388;
      ext_pin_mv = 16'h0000;
      res_stb = 1'b0;
      res_k = 1'b0;
      res_v = 16'h0000;
      mismatches = 0;
      n_tests = 0;
      cyc = 0;
      void'($urandom(32'h3260));
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd_chk(8'h0F, 8'h20);
      rd_chk(8'h0E, 8'h00);
      rd_chk(8'h30, 8'h03);
      lim_chk(7'h20, 1'b1);
      icl_host_model_i.wr8(8'h2E, 8'h00);
      icl_host_model_i.wr8(8'h2F, 8'h00);
      rd_chk(8'h2E, MAKER);
      rd_chk(8'h2F, PART);
      rd_chk(8'h55, 8'h00);
      $display("test reset_and_ids done");
      foreach (VW[i]) begin
         icl_host_model_i.wr16(8'h0A, VW[i]);
         settle();
         out_chk(vlim(VW[i]), vin_lim);
      end
      icl_host_model_i.wr8(8'h0B, 8'hC1);
      rd_chk(8'h0A, 8'h40);
      rd_chk(8'h0B, 8'h01);
      for (int i = 0; i < 6; i++) begin
         v = (i < 2) ? 16'h0DBF + 16'(i) : 16'($urandom_range(3000, 4000));
         vin_mv <= v;
         settle();
         out_chk({15'h0000, v < 16'h0DC0}, {15'h0000, vreg});
      end
      $display("test input_voltage done");
      foreach (CW[i]) begin
         icl_host_model_i.wr8(8'h0F, {1'b0, CW[i]});
         lim_chk(CW[i], 1'b1);
      end
      icl_host_model_i.wr8(8'h0F, 8'h85);
      rd_chk(8'h0F, 8'h7F);
      icl_host_model_i.wr8(8'h30, 8'h02);
      foreach (CW[i]) begin
         icl_host_model_i.wr8(8'h0F, {1'b0, CW[i]});
         lim_chk(CW[i], 1'b0);
      end
      for (int i = 0; i < 6; i++) begin
         c = 7'($urandom_range(1, 127));
         s = 1'($urandom_range(0, 1));
         icl_host_model_i.wr8(8'h30, {6'h00, 1'b1, s});
         icl_host_model_i.wr8(8'h0F, {1'b0, c});
         lim_chk(c, s);
      end
      $display("test input_current done");
      for (int i = 0; i < 2; i++) begin
         s = 1'(i);
         icl_host_model_i.wr8(8'h30, {6'h00, 1'b1, s});
         icl_host_model_i.wr8(8'h0F, 8'h10);
         adapter_present <= 1'b0;
         lim_chk(s ? 7'h20 : 7'h41, s);
         adapter_present <= 1'b1;
         rd_chk(8'h0F, s ? 8'h20 : 8'h41);
      end
      $display("test adapter_removal done");
      ext_pin_mv <= 16'h0FA0;
      settle();
      out_chk(16'h0001, {15'h0000, ext_act});
      ext_pin_mv <= 16'h0FA1;
      settle();
      out_chk(16'h0000, {15'h0000, ext_act});
      ext_pin_mv <= 16'h0FA0;
      icl_host_model_i.wr8(8'h30, 8'h01);
      settle();
      out_chk(16'h0000, {15'h0000, ext_act});
      $display("test external_limit done");
      repeat (4) @(posedge clk);
      summarize();
   end
endmodule
